// ### common/i2cs_pkg.sv
// Package: register map, field positions, reset values and FIFO codes
// Assumes one 40 MHz system clock and a plain strobe-based register port.
`default_nettype none
package i2cs_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_SCTRL = 32'hFFFF0920;
  localparam logic [31:0] ADDR_SSTAT = 32'hFFFF0924;
  localparam logic [31:0] ADDR_SRX = 32'hFFFF0930;
  localparam logic [31:0] ADDR_STX = 32'hFFFF0934;
  localparam logic [31:0] ADDR_ALT = 32'hFFFF0938;
  localparam logic [31:0] ADDR_ID0 = 32'hFFFF093C;
  localparam logic [31:0] ADDR_ID1 = 32'hFFFF0940;
  localparam logic [31:0] ADDR_ID2 = 32'hFFFF0944;
  localparam logic [31:0] ADDR_ID3 = 32'hFFFF0948;
  localparam logic [31:0] ADDR_FSTA = 32'hFFFF094C;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_FSTA = 16'h0000;
  localparam logic [5:0] RST_SCTRL = 6'h00;
  // Slave control bits
  localparam int CT_TX_IRQ = 0;
  localparam int CT_RX_IRQ = 1;
  localparam int CT_EARLY = 2;
  localparam int CT_HWGC = 3;
  localparam int CT_SS_IRQ = 4;
  localparam int CT_RX_FLUSH = 5;
  // Slave status bits
  localparam int ST_SS = 10;
  localparam int ST_OVF = 4;
  localparam int ST_RXQ = 3;
  localparam int ST_TXQ = 2;
  localparam int ST_UF = 1;
  localparam int ST_ET = 0;
  // FIFO status/flush bits
  localparam int FS_MTX_FLUSH = 9;
  localparam int FS_STX_FLUSH = 8;
  // FIFO occupancy codes
  localparam logic [1:0] FIFO_EMPTY = 2'h0;
  localparam logic [1:0] FIFO_JUST = 2'h1;
  localparam logic [1:0] FIFO_ONE = 2'h2;
  localparam logic [1:0] FIFO_FULL = 2'h3;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage
`default_nettype wire

// ### sim/i2c_slave_fifo_status_tb.sv
// Bench: register reads/writes plus serial events through the model
// Assumes the design's one-cycle read latency and clear-on-read of the ET and SS status flags.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_fifo_status_tb;
  logic clk, rstn, wr_en, rd_en, scl_in, sda_in, dir_bit_active, xfer_start;
  logic stop_det, rx_valid, tx_pop, tx_avail, master_tx_flush_q, slave_irq_q;
  logic hw_gc_enable;
  logic [31:0] addr;
  logic [15:0] wr_data, rd_data_q, d;
  logic [7:0] rx_byte, tx_byte, alt_id_q, id0_q, id1_q, id2_q, id3_q;
  logic [1:0] master_rx_state, master_tx_state;
  int n_mismatch, checked;
  i2c_slave_fifo_status dut (.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .scl_in(scl_in), .sda_in(sda_in),
    .dir_bit_active(dir_bit_active), .xfer_start(xfer_start), .stop_det(stop_det),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_pop(tx_pop),
    .master_rx_state(master_rx_state), .master_tx_state(master_tx_state),
    .tx_byte(tx_byte), .tx_avail(tx_avail), .master_tx_flush_q(master_tx_flush_q),
    .slave_irq_q(slave_irq_q), .hw_gc_enable(hw_gc_enable), .alt_id_q(alt_id_q),
    .id0_q(id0_q), .id1_q(id1_q), .id2_q(id2_q), .id3_q(id3_q));
  serial_engine_model em (.clk(clk), .scl_in(scl_in), .sda_in(sda_in),
    .dir_bit_active(dir_bit_active), .xfer_start(xfer_start), .stop_det(stop_det),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_pop(tx_pop));
  // 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic summarize();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge clk) wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge clk) wr_en <= 1'b0;
    wr_data <= ~v;
  endtask
  // Data sampled once the answering edge has settled
  task automatic rd(input logic [31:0] a);
    @(posedge clk) rd_en <= 1'b1;
    addr <= a;
    @(posedge clk) rd_en <= 1'b0;
    #1 d = rd_data_q;
  endtask
  task automatic rchk(input string name, input logic [31:0] a, input logic [15:0] exp);
    rd(a);
    chk(name, d, exp);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    rstn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 32'h00000000;
    wr_data = 16'h0000;
    master_rx_state = 2'h0;
    master_tx_state = 2'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and unmapped places read zero
    for (int i = 0; i < 5; i++) begin
      rchk("id_rst", i2cs_pkg::ADDR_ALT + 4 * i, 16'h0000);
    end
    rchk("srx_rst", i2cs_pkg::ADDR_SRX, 16'h0000);
    rchk("fsta_rst", i2cs_pkg::ADDR_FSTA, 16'h0000);
    rchk("unmapped", 32'hFFFF0950, 16'h0000);
    // ID registers are byte wide: upper write bits must not stick
    for (int i = 0; i < 5; i++) wr(i2cs_pkg::ADDR_ALT + 4 * i, 16'hFF30 + 16'(i));
    for (int i = 0; i < 5; i++) begin
      rchk("id_rw", i2cs_pkg::ADDR_ALT + 4 * i, 16'h0030 + 16'(i));
    end
    @(posedge clk);
    #1 chk("rd_idle", rd_data_q, 16'h0000);
    chk("id01_q", {id0_q, id1_q}, 16'h3132);
    chk("id2_q", {8'h00, id2_q}, 16'h0033);
    chk("id3_q", {8'h00, id3_q}, 16'h0034);
    chk("alt_id_q", {8'h00, alt_id_q}, 16'h0030);
    wr(i2cs_pkg::ADDR_SCTRL, 16'h0008);
    #1 chk("hw_gc", {15'h0000, hw_gc_enable}, 16'h0001);
    wr(i2cs_pkg::ADDR_SCTRL, 16'h0000);
    // Master FIFO codes pass through every value
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) master_rx_state <= 2'(i);
      master_tx_state <= 2'(3 - i);
      rchk("mfifo", i2cs_pkg::ADDR_FSTA, {8'h00, 2'(i), 2'(3 - i), 4'h0});
    end
    // Master codes back to empty so later slave codes read alone
    @(posedge clk) master_rx_state <= 2'h0;
    master_tx_state <= 2'h0;
    // Receive path, with interrupt masked then enabled
    em.send(8'h11);
    rchk("srx_one", i2cs_pkg::ADDR_FSTA, 16'h0008);
    rchk("rxq", i2cs_pkg::ADDR_SSTAT, 16'h0008);
    chk("irq_off", {15'h0000, slave_irq_q}, 16'h0000);
    wr(i2cs_pkg::ADDR_SCTRL, 16'h0002);
    repeat (2) @(posedge clk);
    #1 chk("irq_rx", {15'h0000, slave_irq_q}, 16'h0001);
    em.send(8'h22);
    rchk("srx_full", i2cs_pkg::ADDR_FSTA, 16'h000C);
    em.send(8'h33);
    rchk("ovf", i2cs_pkg::ADDR_SSTAT, 16'h0018);
    rchk("srx_a", i2cs_pkg::ADDR_SRX, 16'h0011);
    rchk("srx_b", i2cs_pkg::ADDR_SRX, 16'h0022);
    rchk("rx_empty", i2cs_pkg::ADDR_SSTAT, 16'h0010);
    em.send(8'h44);
    wr(i2cs_pkg::ADDR_SCTRL, 16'h0022);
    rchk("rx_flush", i2cs_pkg::ADDR_SSTAT, 16'h0000);
    chk("irq_clr", {15'h0000, slave_irq_q}, 16'h0000);
    // Transmit FIFO fill, pop and flush
    wr(i2cs_pkg::ADDR_STX, 16'h005A);
    #1 chk("tx_head", {7'h00, tx_avail, tx_byte}, 16'h015A);
    rchk("stx_rd", i2cs_pkg::ADDR_STX, 16'h0000);
    rchk("stx_one", i2cs_pkg::ADDR_FSTA, 16'h0002);
    wr(i2cs_pkg::ADDR_STX, 16'h00A5);
    rchk("stx_full", i2cs_pkg::ADDR_FSTA, 16'h0003);
    em.pop();
    #1 chk("tx_next", {7'h00, tx_avail, tx_byte}, 16'h01A5);
    wr(i2cs_pkg::ADDR_FSTA, 16'h0100);
    rchk("stx_flush", i2cs_pkg::ADDR_FSTA, 16'h0000);
    chk("tx_avail", {15'h0000, tx_avail}, 16'h0000);
    wr(i2cs_pkg::ADDR_FSTA, 16'h0200);
    #1 chk("mflush", {15'h0000, master_tx_flush_q}, 16'h0001);
    @(posedge clk);
    #1 chk("mflush_end", {15'h0000, master_tx_flush_q}, 16'h0000);
    // Read request, normal timing, transmit FIFO empty
    wr(i2cs_pkg::ADDR_SCTRL, 16'h0011);
    em.dir_rise();
    rchk("rise_std", i2cs_pkg::ADDR_SSTAT, 16'h0003);
    em.dir_fall();
    rchk("fall_std", i2cs_pkg::ADDR_SSTAT, 16'h0006);
    chk("irq_tx", {15'h0000, slave_irq_q}, 16'h0001);
    em.stop();
    rchk("stop", i2cs_pkg::ADDR_SSTAT, 16'h0400);
    chk("irq_ss", {15'h0000, slave_irq_q}, 16'h0001);
    rchk("stop_clr", i2cs_pkg::ADDR_SSTAT, 16'h0000);
    chk("irq_ss_clr", {15'h0000, slave_irq_q}, 16'h0000);
    // Early timing with a loaded FIFO and the transmit interrupt masked
    wr(i2cs_pkg::ADDR_SCTRL, 16'h0004);
    wr(i2cs_pkg::ADDR_STX, 16'h0077);
    em.dir_rise();
    rchk("rise_early", i2cs_pkg::ADDR_SSTAT, 16'h0005);
    chk("irq_mask", {15'h0000, slave_irq_q}, 16'h0000);
    em.dir_fall();
    em.stop();
    rchk("stop2", i2cs_pkg::ADDR_SSTAT, 16'h0400);
    summarize();
  end
endmodule
`default_nettype wire

// ### sim/serial_engine_model.sv
// Far-side model: serial engine events seen while a master addresses us
// Assumes the bench calls its tasks one at a time, in clk time.
`timescale 1ns/10ps
`default_nettype none
module serial_engine_model (
  input wire logic clk, // System clock
  output logic scl_in, // Serial clock level
  output logic sda_in, // Serial data level
  output logic dir_bit_active, // Direction bit window
  output logic xfer_start, // Matched start pulse
  output logic stop_det, // Stop pulse
  output logic rx_valid, // Byte strobe
  output logic [7:0] rx_byte, // Received byte
  output logic tx_pop // Head byte consumed
);
  // Idle bus: both lines pulled high
  initial begin
    scl_in = 1'b1;
    sda_in = 1'b1;
    dir_bit_active = 1'b0;
    xfer_start = 1'b0;
    stop_det = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_pop = 1'b0;
  end
  // Byte in; data inverted afterwards so a stale value never looks valid
  task automatic send(input logic [7:0] b);
    @(posedge clk) rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge clk) rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
  // Matched start, then read bit and its rising clock edge
  task automatic dir_rise();
    @(posedge clk) xfer_start <= 1'b1;
    scl_in <= 1'b0;
    @(posedge clk) xfer_start <= 1'b0;
    dir_bit_active <= 1'b1;
    sda_in <= 1'b1;
    repeat (2) @(posedge clk);
    scl_in <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Falling edge of the read bit; window covers the fall cycle
  task automatic dir_fall();
    @(posedge clk) scl_in <= 1'b0;
    repeat (3) @(posedge clk);
    dir_bit_active <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic stop();
    @(posedge clk) scl_in <= 1'b1;
    @(posedge clk) stop_det <= 1'b1;
    @(posedge clk) stop_det <= 1'b0;
  endtask
  task automatic pop();
    @(posedge clk) tx_pop <= 1'b1;
    @(posedge clk) tx_pop <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verilog/byte_fifo2.sv
// Two-byte shift FIFO with flush and four-value occupancy code
// Assumes push, pop and flush are one-cycle strobes on clk.
`timescale 1ns/10ps
`default_nettype none
module byte_fifo2 (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, low
  input wire logic push, // Write a byte
  input wire logic pop, // Drop the head byte
  input wire logic flush, // Empty the FIFO
  input wire logic [7:0] din, // Byte to write
  output logic [7:0] head, // Oldest byte, from a flop
  output logic [1:0] state_q, // Occupancy code
  output logic nempty_q, // Holds at least one byte
  output logic full_q, // Holds two bytes
  output logic ovf // Push refused, full
);
  logic [7:0] mem_q [0:1];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] slot;
  logic do_pop;
  logic do_push;

  // Pop first so a full FIFO can take a byte in the same cycle
  assign do_pop = pop & (cnt_q != 2'h0) & ~flush;
  assign do_push = push & ~flush & ((cnt_q != i2cs_pkg::FIFO_DEPTH) | do_pop);
  assign ovf = push & ~flush & ~do_push;
  assign slot = cnt_q - {1'b0, do_pop};
  assign cnt_d = flush ? 2'h0 : slot + {1'b0, do_push};
  assign head = mem_q[0];

  // Head always sits in entry 0, so the output needs no read mux
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_q[0] <= i2cs_pkg::RST_BYTE;
      mem_q[1] <= i2cs_pkg::RST_BYTE;
    end else begin
      if (do_pop) begin
        mem_q[0] <= mem_q[1];
      end
      if (do_push) begin
        mem_q[slot[0]] <= din;
      end
    end
  end

  // Count, flags and code track the next occupancy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      nempty_q <= 1'b0;
      full_q <= 1'b0;
      state_q <= i2cs_pkg::FIFO_EMPTY;
    end else begin
      cnt_q <= cnt_d;
      nempty_q <= (cnt_d != 2'h0);
      full_q <= (cnt_d == i2cs_pkg::FIFO_DEPTH);
      if (cnt_d == 2'h0) begin
        state_q <= i2cs_pkg::FIFO_EMPTY;
      end else if (cnt_d == i2cs_pkg::FIFO_DEPTH) begin
        state_q <= i2cs_pkg::FIFO_FULL;
      end else if (do_push) begin
        state_q <= i2cs_pkg::FIFO_JUST;
      end else begin
        state_q <= i2cs_pkg::FIFO_ONE;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/i2c_slave_fifo_status.sv
// Slave status flags, slave data FIFOs, ID registers, FIFO status/flush
// Assumes a serial engine outside that decodes start, stop and address
// match, and feeds bytes and bit timing in as clk-synchronous levels.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_fifo_status (
  input wire logic clk, // 40 MHz system clock
  input wire logic rstn, // Async reset, low
  input wire logic [31:0] addr, // Register byte address
  input wire logic [15:0] wr_data, // Register write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [15:0] rd_data_q, // Read data, cycle after rd_en
  input wire logic scl_in, // Serial clock level
  input wire logic sda_in, // Serial data level
  input wire logic dir_bit_active, // Direction bit of a matched address
  input wire logic xfer_start, // Start with matching address
  input wire logic stop_det, // Stop condition seen
  input wire logic rx_valid, // Received byte strobe
  input wire logic [7:0] rx_byte, // Received byte
  input wire logic tx_pop, // Engine took the head tx byte
  input wire logic [1:0] master_rx_state, // Master rx FIFO code
  input wire logic [1:0] master_tx_state, // Master tx FIFO code
  output logic [7:0] tx_byte, // Head tx byte
  output logic tx_avail, // Tx FIFO not empty
  output logic master_tx_flush_q, // Flush pulse to master tx FIFO
  output logic slave_irq_q, // Slave interrupt request
  output logic hw_gc_enable, // Hardware general call enable
  output logic [7:0] alt_id_q, // Alternate ID
  output logic [7:0] id0_q, // Slave ID 0
  output logic [7:0] id1_q, // Slave ID 1
  output logic [7:0] id2_q, // Slave ID 2
  output logic [7:0] id3_q // Slave ID 3
);
  logic [5:0] ctrl_q;
  logic ovf_q;
  logic txq_q;
  logic uf_q;
  logic et_q;
  logic ss_q;
  logic et_armed_q;
  logic in_xfer_q;
  logic dir_read_q;
  logic rise;
  logic fall;
  logic [7:0] rx_head;
  logic [1:0] rx_state;
  logic rx_nempty;
  logic rx_full;
  logic rx_ovf;
  logic [1:0] tx_state;
  logic tx_full;

  // Address decode
  wire sel_ctrl = (addr == i2cs_pkg::ADDR_SCTRL);
  wire sel_stat = (addr == i2cs_pkg::ADDR_SSTAT);
  wire sel_srx = (addr == i2cs_pkg::ADDR_SRX);
  wire sel_stx = (addr == i2cs_pkg::ADDR_STX);
  wire sel_alt = (addr == i2cs_pkg::ADDR_ALT);
  wire sel_id0 = (addr == i2cs_pkg::ADDR_ID0);
  wire sel_id1 = (addr == i2cs_pkg::ADDR_ID1);
  wire sel_id2 = (addr == i2cs_pkg::ADDR_ID2);
  wire sel_id3 = (addr == i2cs_pkg::ADDR_ID3);
  wire sel_fsta = (addr == i2cs_pkg::ADDR_FSTA);

  // Control fields
  wire tx_irq_en = ctrl_q[i2cs_pkg::CT_TX_IRQ];
  wire rx_irq_en = ctrl_q[i2cs_pkg::CT_RX_IRQ];
  wire early_en = ctrl_q[i2cs_pkg::CT_EARLY];
  wire ss_irq_en = ctrl_q[i2cs_pkg::CT_SS_IRQ];
  assign hw_gc_enable = ctrl_q[i2cs_pkg::CT_HWGC];

  // Software strobes; flush has priority inside the FIFO
  wire rx_pop = rd_en & sel_srx;
  wire rx_flush = wr_en & sel_ctrl & wr_data[i2cs_pkg::CT_RX_FLUSH];
  wire tx_push = wr_en & sel_stx;
  wire tx_flush = wr_en & sel_fsta & wr_data[i2cs_pkg::FS_STX_FLUSH];
  wire mtx_flush = wr_en & sel_fsta & wr_data[i2cs_pkg::FS_MTX_FLUSH];
  wire stat_rd = rd_en & sel_stat;

  // Bit-timing events of the direction bit
  wire dir_rise = dir_bit_active & rise;
  wire read_rise = dir_rise & sda_in;
  wire read_fall = dir_bit_active & fall & dir_read_q;
  wire txq_set = early_en ? read_rise : read_fall;
  wire uf_set = read_rise & ~tx_avail;
  // Early mode warns on either direction, before any data bit moves
  wire et_hit = early_en ? dir_rise : ~tx_avail;
  wire et_set = et_armed_q & et_hit;
  wire ss_set = stop_det & in_xfer_q;
  wire xfer_edge = xfer_start | stop_det;

  scl_edge u_edge (
    .clk(clk),
    .rstn(rstn),
    .scl_in(scl_in),
    .rise(rise),
    .fall(fall)
  );

  // Two-byte receive FIFO, filled from the serial side
  byte_fifo2 u_rx (
    .clk(clk),
    .rstn(rstn),
    .push(rx_valid),
    .pop(rx_pop),
    .flush(rx_flush),
    .din(rx_byte),
    .head(rx_head),
    .state_q(rx_state),
    .nempty_q(rx_nempty),
    .full_q(rx_full),
    .ovf(rx_ovf)
  );

  // Two-byte transmit FIFO, filled by software
  byte_fifo2 u_tx (
    .clk(clk),
    .rstn(rstn),
    .push(tx_push),
    .pop(tx_pop),
    .flush(tx_flush),
    .din(wr_data[7:0]),
    .head(tx_byte),
    .state_q(tx_state),
    .nempty_q(tx_avail),
    .full_q(tx_full),
    .ovf()
  );

  // Status and FIFO words as software sees them
  wire [15:0] stat_word = {5'h00, ss_q, 5'h00, ovf_q, rx_nempty, txq_q, uf_q, et_q};
  wire [15:0] fsta_word = {8'h00, master_rx_state, master_tx_state, rx_state, tx_state};

  // Read mux; unmapped and write-only addresses read zero
  wire [15:0] rd_mux =
    sel_ctrl ? {10'h000, ctrl_q} :
    sel_stat ? stat_word :
    sel_srx ? {8'h00, rx_head} :
    sel_alt ? {8'h00, alt_id_q} :
    sel_id0 ? {8'h00, id0_q} :
    sel_id1 ? {8'h00, id1_q} :
    sel_id2 ? {8'h00, id2_q} :
    sel_id3 ? {8'h00, id3_q} :
    sel_fsta ? fsta_word :
    16'h0000;

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= i2cs_pkg::RST_FSTA;
    end else begin
      rd_data_q <= rd_en ? rd_mux : 16'h0000;
    end
  end

  // Writable byte registers; flush bit of control never stores
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= i2cs_pkg::RST_SCTRL;
      alt_id_q <= i2cs_pkg::RST_BYTE;
      id0_q <= i2cs_pkg::RST_BYTE;
      id1_q <= i2cs_pkg::RST_BYTE;
      id2_q <= i2cs_pkg::RST_BYTE;
      id3_q <= i2cs_pkg::RST_BYTE;
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl_q <= {1'b0, wr_data[4:0]};
      end
      if (sel_alt) begin
        alt_id_q <= wr_data[7:0];
      end
      if (sel_id0) begin
        id0_q <= wr_data[7:0];
      end
      if (sel_id1) begin
        id1_q <= wr_data[7:0];
      end
      if (sel_id2) begin
        id2_q <= wr_data[7:0];
      end
      if (sel_id3) begin
        id3_q <= wr_data[7:0];
      end
    end
  end

  // Master tx flush leaves as a one-cycle pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      master_tx_flush_q <= 1'b0;
    end else begin
      master_tx_flush_q <= mtx_flush;
    end
  end

  // Transfer tracking: direction latched at the bit's rising edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_read_q <= 1'b0;
      in_xfer_q <= 1'b0;
      et_armed_q <= 1'b0;
    end else begin
      if (dir_bit_active & rise) begin
        dir_read_q <= sda_in;
      end
      in_xfer_q <= xfer_start | (in_xfer_q & ~stop_det);
      et_armed_q <= xfer_start | (et_armed_q & ~et_set);
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_q <= 1'b0;
      txq_q <= 1'b0;
      uf_q <= 1'b0;
      et_q <= 1'b0;
      ss_q <= 1'b0;
    end else begin
      ovf_q <= rx_ovf | (ovf_q & ~(rx_valid | rx_flush));
      txq_q <= txq_set | (txq_q & ~(xfer_edge | tx_push));
      uf_q <= uf_set | (uf_q & ~(xfer_edge | tx_push));
      et_q <= et_set | (et_q & ~stat_rd);
      ss_q <= ss_set | (ss_q & ~stat_rd);
    end
  end

  // One request line; each source gated by its own enable
  wire irq_src = (rx_nempty & rx_irq_en) |
    (txq_q & tx_irq_en) |
    (ss_q & ss_irq_en);

  // Registered so the request line never glitches on decode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slave_irq_q <= 1'b0;
    end else begin
      slave_irq_q <= irq_src;
    end
  end

  property p_ovf;
    @(posedge clk) disable iff (!rstn)
      rx_valid & rx_full & ~rx_pop & ~rx_flush |=> ovf_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missed");

  property p_rxq;
    @(posedge clk) disable iff (!rstn)
      rx_valid & ~rx_flush |=> rx_nempty && stat_word[i2cs_pkg::ST_RXQ];
  endproperty
  a_rxq: assert property (p_rxq) else $error("rx request not raised");

  property p_rxq_hold;
    @(posedge clk) disable iff (!rstn)
      rx_nempty & ~rx_pop & ~rx_flush |=> rx_nempty;
  endproperty
  a_rxq_hold: assert property (p_rxq_hold) else $error("rx request dropped");

  property p_irq_cause;
    @(posedge clk) disable iff (!rstn)
      slave_irq_q |-> $past(irq_src);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled source");

  property p_txq_late;
    @(posedge clk) disable iff (!rstn)
      ~early_en & read_fall |=> txq_q;
  endproperty
  a_txq_late: assert property (p_txq_late) else $error("tx request late edge missed");

  property p_txq_early;
    @(posedge clk) disable iff (!rstn)
      early_en & read_rise |=> txq_q;
  endproperty
  a_txq_early: assert property (p_txq_early) else $error("tx request early edge missed");

  property p_uf;
    @(posedge clk) disable iff (!rstn)
      read_rise & ~tx_avail |=> uf_q;
  endproperty
  a_uf: assert property (p_uf) else $error("underflow not flagged");

  property p_et_once;
    @(posedge clk) disable iff (!rstn)
      et_set & ~xfer_start |=> ~et_armed_q;
  endproperty
  a_et_once: assert property (p_et_once) else $error("early flag rearmed");

  property p_ss;
    @(posedge clk) disable iff (!rstn)
      stop_det & in_xfer_q |=> ss_q ##1 (ss_q | $past(stat_rd));
  endproperty
  a_ss: assert property (p_ss) else $error("stop after start lost");

  property p_mflush;
    @(posedge clk) disable iff (!rstn)
      mtx_flush ##1 ~mtx_flush |-> master_tx_flush_q ##1 ~master_tx_flush_q;
  endproperty
  a_mflush: assert property (p_mflush) else $error("master flush pulse wrong");

  property p_sflush;
    @(posedge clk) disable iff (!rstn)
      tx_flush |=> ~tx_avail && tx_state == i2cs_pkg::FIFO_EMPTY;
  endproperty
  a_sflush: assert property (p_sflush) else $error("slave tx flush failed");

  property p_id_read;
    @(posedge clk) disable iff (!rstn)
      rd_en & sel_id2 |=> rd_data_q == {8'h00, $past(id2_q)};
  endproperty
  a_id_read: assert property (p_id_read) else $error("id read mismatch");

  property p_et_early;
    @(posedge clk) disable iff (!rstn)
      early_en & et_armed_q & dir_rise |=> et_q;
  endproperty
  a_et_early: assert property (p_et_early) else $error("early flag missed");

  property p_rx_read;
    @(posedge clk) disable iff (!rstn)
      rx_pop |=> rd_data_q == {8'h00, $past(rx_head)};
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx data read mismatch");

  property p_tx_push;
    @(posedge clk) disable iff (!rstn)
      tx_push & ~tx_full & ~tx_flush |=> tx_avail;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("tx byte not taken");

  property p_fsta_read;
    @(posedge clk) disable iff (!rstn)
      rd_en & sel_fsta |=> rd_data_q[15:8] == 8'h00 && rd_data_q[7:6] == $past(master_rx_state)
        && rd_data_q[3:2] == $past(rx_state);
  endproperty
  a_fsta_read: assert property (p_fsta_read) else $error("fifo status read mismatch");
endmodule
`default_nettype wire

// ### verilog/scl_edge.sv
// Serial clock edge detector
// Assumes scl_in is already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module scl_edge (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, low
  input wire logic scl_in, // Serial clock level
  output logic rise, // One-cycle pulse on rise
  output logic fall // One-cycle pulse on fall
);
  logic prev_q;

  // Reset high so an idle bus shows no edge at release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= scl_in;
    end
  end

  assign rise = scl_in & ~prev_q;
  assign fall = ~scl_in & prev_q;
endmodule
`default_nettype wire
